//--- rtl/pfb_map.svh
// Timing counts and field positions for the parallel flash bus controller.
`ifndef PFB_MAP_SVH
`define PFB_MAP_SVH
`define PFB_CLK_PERIOD_NS 20
`define PFB_ACCESS_NS 70
`define PFB_ACCESS_CYC ((`PFB_ACCESS_NS + `PFB_CLK_PERIOD_NS - 1) / `PFB_CLK_PERIOD_NS)
`define PFB_WRPULSE_NS 35
`define PFB_WRPULSE_CYC ((`PFB_WRPULSE_NS + `PFB_CLK_PERIOD_NS - 1) / `PFB_CLK_PERIOD_NS)
`define PFB_RSTPULSE_NS 500
`define PFB_RSTPULSE_CYC ((`PFB_RSTPULSE_NS + `PFB_CLK_PERIOD_NS - 1) / `PFB_CLK_PERIOD_NS)
`define PFB_RSTWAIT_NS 50
`define PFB_RSTWAIT_CYC ((`PFB_RSTWAIT_NS + `PFB_CLK_PERIOD_NS - 1) / `PFB_CLK_PERIOD_NS)
`define PFB_RDYWAIT_NS 20
`define PFB_RDYWAIT_CYC ((`PFB_RDYWAIT_NS + `PFB_CLK_PERIOD_NS - 1) / `PFB_CLK_PERIOD_NS)
`define PFB_READY_NS 20000
`define PFB_READY_CYC ((`PFB_READY_NS + `PFB_CLK_PERIOD_NS - 1) / `PFB_CLK_PERIOD_NS)
`define PFB_BYTE_ADDR_BIT 15
`endif

//--- rtl/pfb_pkg.sv
// Types shared by the parallel flash bus controller.
package pfb_pkg;
  typedef enum logic [2:0] {
    PFB_IDLE,
    PFB_RD_SETUP,
    PFB_RD_WAIT,
    PFB_WR_PULSE,
    PFB_WR_HOLD,
    PFB_RST_PULSE,
    PFB_RST_READY,
    PFB_RST_RECOVER
  } pfb_state_t;
endpackage : pfb_pkg

//--- rtl/pfb_timer.sv
// Down counter that times every phase of the flash bus sequence except the one-cycle write hold.
`timescale 1ns/1ps
module pfb_timer #(
  parameter int WIDTH = 16
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_in,
  // Load and status.
  input wire logic load_in,
  input wire logic [WIDTH-1:0] count_in,
  output logic done_out
);
  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;

  // A counter without bits could not time anything.
  if (WIDTH < 1)
  begin : g_width_check
    $error("pfb_timer: WIDTH must be at least one");
  end

  // Count to zero after a load; done holds while the count rests at zero.
  always_comb
  begin
    cnt_d = cnt_q;
    if (load_in)
    begin
      cnt_d = count_in;
    end
    else if (cnt_q != '0)
    begin
      cnt_d = cnt_q - WIDTH'(1);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt_q <= '0;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

  // Done comes from the register alone, because the sequencer loads on done and a gate
  // by the load would close a combinational loop.
  assign done_out = (cnt_q == '0);
endmodule : pfb_timer

//--- rtl/pfb_host.sv
// Host-side controller that drives a parallel flash through its bus pins.
// Functional notes
// - Writes hold chip select and write enable low with output enable high.
// - Word mode uses sixteen data lines; byte mode only the low eight.
// - In byte mode the top data line carries the low address bit.
// - Reads wait the full access delay after leaving standby.
// - Operations cut by reset must be reissued by the requester.
// - After busy reset, wait for ready then the post ready delay.
// - Idle reset waits the reset pulse then the post reset delay.
`timescale 1ns/1ps
`include "pfb_map.svh"
module pfb_host #(
  parameter int ADDR_W = 20,
  parameter int READY_CYC = `PFB_READY_CYC
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_in,
  // User request port.
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic req_byte_in,
  input wire logic [ADDR_W:0] req_addr_in,
  input wire logic [15:0] req_wdata_in,
  input wire logic flash_reset_req_in,
  output logic req_ready_out,
  output logic rsp_valid_out,
  output logic [15:0] rsp_rdata_out,
  output logic reset_aborted_out,
  // Flash pins.
  output logic ce_n_out,
  output logic oe_n_out,
  output logic we_n_out,
  output logic reset_n_out,
  output logic byte_n_out,
  output logic [ADDR_W-1:0] addr_out,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic [15:0] dq_oe_out,
  input wire logic ready_busy_n_in
);
  import pfb_pkg::*;

  localparam int TW = 16;

  // The timer width must hold the longest wait.
  if (ADDR_W < 1 || READY_CYC < 1 || READY_CYC >= (1 << TW))
  begin : g_param_check
    $error("pfb_host: unsupported parameter values");
  end

  pfb_state_t st_q, st_d;
  logic ce_n_q, ce_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d, rst_n_q, rst_n_d;
  logic byte_n_q, byte_n_d, rsp_q, rsp_d, abort_q, abort_d, rdy_q, rdy_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [15:0] dq_q, dq_d, oe_q, oe_d, rdata_q, rdata_d;
  logic busy_at_rst_q, busy_at_rst_d;
  logic tload;
  logic [TW-1:0] tcount;
  logic tdone;

  // Time base for every bus phase but the one-cycle write hold.
  pfb_timer #(.WIDTH(TW)) u_timer (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .load_in(tload),
    .count_in(tcount),
    .done_out(tdone)
  );

  // Converts a cycle count into a timer load value.
  function automatic logic [TW-1:0] cyc(input int n);
    cyc = TW'(n - 1);
  endfunction : cyc

  // Sequencer for reads, writes and hardware reset of the flash.
  always_comb
  begin
    st_d = st_q;
    ce_n_d = ce_n_q;
    oe_n_d = oe_n_q;
    we_n_d = we_n_q;
    rst_n_d = rst_n_q;
    byte_n_d = byte_n_q;
    addr_d = addr_q;
    dq_d = dq_q;
    oe_d = oe_q;
    rdata_d = rdata_q;
    rsp_d = 1'b0;
    abort_d = 1'b0;
    rdy_d = 1'b0;
    busy_at_rst_d = busy_at_rst_q;
    tload = 1'b0;
    tcount = '0;
    case (st_q)
      PFB_IDLE:
      begin
        if (flash_reset_req_in)
        begin
          // Reset takes priority; flash floats data so host drives nothing.
          busy_at_rst_d = !ready_busy_n_in;
          abort_d = !ready_busy_n_in;
          rst_n_d = 1'b0;
          ce_n_d = 1'b1;
          oe_d = 16'h0000;
          tload = 1'b1;
          tcount = cyc(`PFB_RSTPULSE_CYC);
          st_d = PFB_RST_PULSE;
        end
        else if (req_valid_in)
        begin
          byte_n_d = !req_byte_in;
          addr_d = req_addr_in[ADDR_W:1];
          if (!req_byte_in)
          begin
            addr_d = req_addr_in[ADDR_W-1:0];
          end
          ce_n_d = 1'b0;
          tload = 1'b1;
          if (req_write_in)
          begin
            // Output enable stays high so the bus is ours.
            oe_n_d = 1'b1;
            dq_d = req_byte_in ? {8'h00, req_wdata_in[7:0]} : req_wdata_in;
            oe_d = req_byte_in ? 16'h00FF : 16'hFFFF;
            tcount = cyc(1);
            st_d = PFB_WR_PULSE;
          end
          else
          begin
            oe_n_d = 1'b0;
            dq_d = 16'h0000;
            oe_d = 16'h0000;
            tcount = cyc(`PFB_ACCESS_CYC);
            st_d = PFB_RD_WAIT;
          end
          if (req_byte_in)
          begin
            // Top data line carries the lowest address bit.
            dq_d[`PFB_BYTE_ADDR_BIT] = req_addr_in[0];
            oe_d[`PFB_BYTE_ADDR_BIT] = 1'b1;
          end
        end
        else
        begin
          rdy_d = 1'b1;
        end
      end
      PFB_RD_WAIT:
      begin
        if (tdone)
        begin
          rdata_d = byte_n_q ? dq_in : {8'h00, dq_in[7:0]};
          rsp_d = 1'b1;
          ce_n_d = 1'b1;
          oe_n_d = 1'b1;
          oe_d = 16'h0000;
          st_d = PFB_IDLE;
        end
      end
      PFB_RD_SETUP:
      begin
        st_d = PFB_IDLE;
      end
      PFB_WR_PULSE:
      begin
        // Address was set up a cycle earlier, before the later falling strobe.
        if (tdone && we_n_q)
        begin
          we_n_d = 1'b0;
          tload = 1'b1;
          tcount = cyc(`PFB_WRPULSE_CYC);
        end
        else if (tdone)
        begin
          we_n_d = 1'b1;
          st_d = PFB_WR_HOLD;
        end
      end
      PFB_WR_HOLD:
      begin
        // Data and address hold one cycle past the rising strobe.
        ce_n_d = 1'b1;
        oe_d = 16'h0000;
        rsp_d = 1'b1;
        st_d = PFB_IDLE;
      end
      PFB_RST_PULSE:
      begin
        if (tdone)
        begin
          rst_n_d = 1'b1;
          tload = 1'b1;
          tcount = busy_at_rst_q ? cyc(READY_CYC) : cyc(`PFB_RSTWAIT_CYC);
          st_d = busy_at_rst_q ? PFB_RST_READY : PFB_RST_RECOVER;
        end
      end
      PFB_RST_READY:
      begin
        // Busy flash finishes its internal reset; the timer caps the wait.
        if (ready_busy_n_in || tdone)
        begin
          tload = 1'b1;
          tcount = cyc(`PFB_RDYWAIT_CYC);
          st_d = PFB_RST_RECOVER;
        end
      end
      PFB_RST_RECOVER:
      begin
        if (tdone)
        begin
          st_d = PFB_IDLE;
        end
      end
      default:
      begin
        st_d = PFB_IDLE;
      end
    endcase
  end

  // State registers; reset leaves the flash deselected and the bus released.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_q <= PFB_IDLE;
      ce_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      rst_n_q <= 1'b1;
      byte_n_q <= 1'b1;
      addr_q <= '0;
      dq_q <= 16'h0000;
      oe_q <= 16'h0000;
      rdata_q <= 16'h0000;
      rsp_q <= 1'b0;
      abort_q <= 1'b0;
      rdy_q <= 1'b0;
      busy_at_rst_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      ce_n_q <= ce_n_d;
      oe_n_q <= oe_n_d;
      we_n_q <= we_n_d;
      rst_n_q <= rst_n_d;
      byte_n_q <= byte_n_d;
      addr_q <= addr_d;
      dq_q <= dq_d;
      oe_q <= oe_d;
      rdata_q <= rdata_d;
      rsp_q <= rsp_d;
      abort_q <= abort_d;
      rdy_q <= rdy_d;
      busy_at_rst_q <= busy_at_rst_d;
    end
  end

  assign req_ready_out = rdy_q;
  assign rsp_valid_out = rsp_q;
  assign rsp_rdata_out = rdata_q;
  assign reset_aborted_out = abort_q;
  assign ce_n_out = ce_n_q;
  assign oe_n_out = oe_n_q;
  assign we_n_out = we_n_q;
  assign reset_n_out = rst_n_q;
  assign byte_n_out = byte_n_q;
  assign addr_out = addr_q;
  assign dq_out = dq_q;
  assign dq_oe_out = oe_q;
endmodule : pfb_host

//--- verification/pfb_host_props.sv
// Checker on the flash bus pins of the host controller.
`timescale 1ns/1ps
module pfb_host_props (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_in,
  // Observed outputs.
  input wire logic rsp_valid_out,
  input wire logic ce_n_out,
  input wire logic oe_n_out,
  input wire logic we_n_out,
  input wire logic reset_n_out,
  input wire logic byte_n_out,
  input wire logic [19:0] addr_out,
  input wire logic [15:0] dq_out,
  input wire logic [15:0] dq_oe_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Bus relations; the read length is tied to the four access cycles.
  property p_wr_ctl; !we_n_out |-> !ce_n_out && oe_n_out; endproperty
  a_wr_ctl: assert property (p_wr_ctl) else $error("bad write strobes");
  property p_wr_addr; !we_n_out |-> $stable(addr_out); endproperty
  a_wr_addr: assert property (p_wr_addr) else $error("address moved");
  property p_wr_data; $rose(we_n_out) |-> $stable(dq_out) && !ce_n_out; endproperty
  a_wr_data: assert property (p_wr_data) else $error("data moved");
  property p_lanes; !byte_n_out && !ce_n_out |-> dq_oe_out[14:8] == 7'h00; endproperty
  a_lanes: assert property (p_lanes) else $error("upper lanes driven");
  property p_lsb; !byte_n_out && !ce_n_out |-> dq_oe_out[15]; endproperty
  a_lsb: assert property (p_lsb) else $error("low address bit not driven");
  property p_float; !oe_n_out |-> dq_oe_out[7:0] == 8'h00; endproperty
  a_float: assert property (p_float) else $error("contention on read");
  property p_rd_len; $fell(oe_n_out) |-> !oe_n_out [*4] ##1 rsp_valid_out; endproperty
  a_rd_len: assert property (p_rd_len) else $error("short read access");
  property p_rst_len; $fell(reset_n_out) |-> !reset_n_out [*8]; endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset pulse short");
  property p_rst_q; !reset_n_out |-> ce_n_out && we_n_out && oe_n_out; endproperty
  a_rst_q: assert property (p_rst_q) else $error("access during reset");
  c_rd: cover property ($fell(oe_n_out));
  c_wr: cover property ($rose(we_n_out));
  c_rst: cover property ($rose(reset_n_out));
endmodule : pfb_host_props

//--- verification/pfb_flash_model.sv
// Behavioural flash device answering the controller's bus cycles.
`timescale 1ns/1ps
module pfb_flash_model (
  // Flash pins.
  input wire logic ce_n_in,
  input wire logic oe_n_in,
  input wire logic we_n_in,
  input wire logic reset_n_in,
  input wire logic byte_n_in,
  input wire logic [19:0] addr_in,
  input wire logic [15:0] hdq_in,
  input wire logic [15:0] hoe_in,
  // Bench control and answers.
  input wire logic busy_in,
  output logic [15:0] dq_out,
  output logic ready_busy_n_out
);
  logic [7:0] mem [int];
  logic [20:0] a;
  logic armed = 1'b0;
  logic [15:0] last = 16'h0000;
  logic busy = 1'b0;
  wire drv = !ce_n_in && !oe_n_in && reset_n_in;
  wire [20:0] ra = {addr_in, byte_n_in ? 1'b0 : hdq_in[15]};
  function automatic logic [7:0] rd(input int x);
    return mem.exists(x) ? mem[x] : 8'hFF;
  endfunction : rd
  // Address at the later falling strobe; only a real overlap of both strobes arms a write.
  always @(negedge (ce_n_in | we_n_in))
  begin
    a = ra;
    armed = 1'b1;
  end
  // Data at the first rising strobe, only with output enable high.
  // The armed flag keeps the strobes' first rise out of reset from storing anything.
  always @(posedge (ce_n_in | we_n_in))
  begin
    if (armed && oe_n_in && reset_n_in)
    begin
      mem[a] = hdq_in[7:0];
      if (byte_n_in)
        mem[a + 1] = hdq_in[15:8];
    end
    armed = 1'b0;
  end
  // Released lines show the inverse of the last value, never a stale copy.
  // Only a selected part with output enable low and reset high drives its data on the lines.
  always @*
  begin
    for (int i = 0; i < 16; i++)
      dq_out[i] = hoe_in[i] ? hdq_in[i] : ~last[i];
    if (drv)
      dq_out[7:0] = rd(ra);
    if (drv && byte_n_in)
      dq_out[15:8] = rd(ra + 1);
  end
  always @(posedge ce_n_in)
    last <= dq_out;
  // Busy survives deselect; a reset ends it a while after release.
  always @(posedge busy_in or posedge reset_n_in)
  begin
    if (reset_n_in && busy)
      busy <= #400 1'b0;
    else if (busy_in)
      busy <= 1'b1;
  end
  assign ready_busy_n_out = !busy;
endmodule : pfb_flash_model

//--- verification/pfb_host_bench.sv
// Self-checking bench for the parallel flash host controller.
`timescale 1ns/1ps
module pfb_host_bench;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic vld = 1'b0;
  logic wr = 1'b0;
  logic by = 1'b0;
  logic [20:0] ad = 21'h000000;
  logic [15:0] wd = 16'h0000;
  logic frq = 1'b0;
  logic bsy = 1'b0;
  logic req_ready_out, rsp_valid_out, reset_aborted_out, ready_busy_n;
  logic ce_n, oe_n, we_n, rst_n, byte_n;
  logic [15:0] rsp_rdata_out, fdq, hdq, hoe;
  logic [19:0] addr;
  logic [7:0] ref_m [int];
  int miscompares = 0;
  int num_checks = 0;
  pfb_host #(.READY_CYC(40)) dut (.clk_in(clk_in), .rst_in(rst_in), .req_valid_in(vld),
    .req_write_in(wr), .req_byte_in(by), .req_addr_in(ad), .req_wdata_in(wd),
    .flash_reset_req_in(frq), .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
    .rsp_rdata_out(rsp_rdata_out), .reset_aborted_out(reset_aborted_out), .ce_n_out(ce_n),
    .oe_n_out(oe_n), .we_n_out(we_n), .reset_n_out(rst_n), .byte_n_out(byte_n),
    .addr_out(addr), .dq_in(fdq), .dq_out(hdq), .dq_oe_out(hoe),
    .ready_busy_n_in(ready_busy_n));
  pfb_flash_model flash (.ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n), .reset_n_in(rst_n),
    .byte_n_in(byte_n), .addr_in(addr), .hdq_in(hdq), .hoe_in(hoe), .busy_in(bsy),
    .dq_out(fdq), .ready_busy_n_out(ready_busy_n));
  // Free-running 50 MHz clock.
  initial
  begin
    forever #10 clk_in = ~clk_in;
  end
  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask : chk
  // One bounded clock step; running out of budget ends the run.
  task automatic step(inout int n);
    @(posedge clk_in);
    #1;
    n++;
    if (n > 3000)
    begin
      miscompares++;
      report_and_stop();
    end
  endtask : step
  function automatic logic [7:0] rd(input int x);
    return ref_m.exists(x) ? ref_m[x] : 8'hFF;
  endfunction : rd
  task automatic op(input logic w, input logic b, input logic [20:0] a, input logic [15:0] d);
    int n;
    logic [15:0] e;
    n = 0;
    e = b ? {8'h00, rd(a)} : {rd({a[19:0], 1'b1}), rd({a[19:0], 1'b0})};
    while (req_ready_out !== 1'b1) step(n);
    {vld, wr, by, ad, wd} = {1'b1, w, b, a, d};
    step(n);
    vld = 1'b0;
    step(n);
    chk("addr", b ? {12'h000, a[20:1]} : {12'h000, a[19:0]}, {12'h000, addr});
    chk("byte", {31'h0, !b}, {31'h0, byte_n});
    while (rsp_valid_out !== 1'b1) step(n);
    if (!w)
      chk("rdata", {16'h0000, e}, {16'h0000, rsp_rdata_out});
    else
    begin
      ref_m[b ? a : {a[19:0], 1'b0}] = d[7:0];
      if (!b)
        ref_m[{a[19:0], 1'b1}] = d[15:8];
    end
  endtask : op
  task automatic rst_op(input logic bz);
    int n;
    int ab;
    n = 0;
    ab = 0;
    bsy = bz;
    while (req_ready_out !== 1'b1) step(n);
    frq = 1'b1;
    step(n);
    frq = 1'b0;
    while (req_ready_out !== 1'b1)
    begin
      ab += (reset_aborted_out === 1'b1);
      step(n);
    end
    chk("aborted", {31'h0, bz}, ab);
    chk("ready", 32'h00000001, {31'h0, ready_busy_n});
    bsy = 1'b0;
  endtask : rst_op
  // Main sequence: random traffic around two address corners, then both reset kinds.
  initial
  begin
    logic [20:0] a;
    void'($urandom(89079));
    repeat (16) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    for (int i = 0; i < 40; i++)
    begin
      a = ($urandom % 2) ? (21'h1FFFE0 | 21'($urandom % 32)) : 21'($urandom % 32);
      op(1'($urandom), 1'($urandom), a, 16'($urandom));
      op(1'b0, 1'($urandom), a, 16'h0000);
    end
    rst_op(1'b0);
    op(1'b0, 1'b0, a, 16'h0000);
    rst_op(1'b1);
    op(1'b0, 1'b1, a, 16'h0000);
    report_and_stop();
  end
endmodule : pfb_host_bench
bind pfb_host pfb_host_props props (.clk_in(clk_in), .rst_in(rst_in),
  .rsp_valid_out(rsp_valid_out), .ce_n_out(ce_n_out), .oe_n_out(oe_n_out),
  .we_n_out(we_n_out), .reset_n_out(reset_n_out), .byte_n_out(byte_n_out),
  .addr_out(addr_out), .dq_out(dq_out), .dq_oe_out(dq_oe_out));
